/* File: pkg/asramc_pkg.sv */
// Purpose: Constants for the asynchronous 1M x 8 static RAM controller
// Assumes: 100 MHz core clock, 10 ns period
// Notes: Times in ns, cycle counts rounded up from them
package asramc_pkg;
    localparam int CLK_PERIOD_NS = 10;
    localparam int ADDR_W = 20;
    localparam int DATA_W = 8;
    // Least and greatest times (round up)
    localparam int ADDR_SETUP_TO_END_NS = 35;
    localparam int WRITE_PULSE_NS = 35;
    localparam int DATA_SETUP_TO_END_NS = 25;
    localparam int WRITE_PERIOD_MIN_NS = 45;
    localparam int READ_PERIOD_MIN_NS = 45;
    localparam int ADDR_TO_VALID_MAX_NS = 45;
    localparam int STROBE_TO_VALID_MAX_NS = 22;
    localparam int SELECT_TO_VALID_MAX_NS = 45;
    localparam int STROBE_HIGH_TO_FLOAT_NS = 18;
    localparam int DESELECT_TO_FLOAT_NS = 18;
    localparam int WRITE_LOW_TO_FLOAT_NS = 18;
    localparam int CEIL_DIV_ADJ = CLK_PERIOD_NS - 1;
    localparam int WR_PULSE_CYC =
        (WRITE_PULSE_NS + CEIL_DIV_ADJ) / CLK_PERIOD_NS;
    localparam int WR_DATA_CYC =
        (DATA_SETUP_TO_END_NS + CEIL_DIV_ADJ) / CLK_PERIOD_NS;
    localparam int WR_ADDR_CYC =
        (ADDR_SETUP_TO_END_NS + CEIL_DIV_ADJ) / CLK_PERIOD_NS;
    localparam int WR_PERIOD_CYC =
        (WRITE_PERIOD_MIN_NS + CEIL_DIV_ADJ) / CLK_PERIOD_NS;
    localparam int RD_ACCESS_NS = ADDR_TO_VALID_MAX_NS;
    // Sample one cycle after the worst access so data has settled in
    localparam int RD_WAIT_CYC =
        (RD_ACCESS_NS + CEIL_DIV_ADJ) / CLK_PERIOD_NS + 1;
    localparam int RD_PERIOD_CYC =
        (READ_PERIOD_MIN_NS + CEIL_DIV_ADJ) / CLK_PERIOD_NS;
    // Bus turnaround after a read before the controller drives data
    localparam int TURN_CYC =
        (STROBE_HIGH_TO_FLOAT_NS + CEIL_DIV_ADJ) / CLK_PERIOD_NS;
    localparam int CNT_W = 4;
    localparam logic [CNT_W-1:0] WR_PULSE_CNT = CNT_W'(WR_PULSE_CYC);
    localparam logic [CNT_W-1:0] WR_TAIL_CNT = CNT_W'(WR_PERIOD_CYC - WR_PULSE_CYC);
    localparam logic [CNT_W-1:0] RD_WAIT_CNT = CNT_W'(RD_WAIT_CYC);
    localparam logic [CNT_W-1:0] TURN_CNT = CNT_W'(TURN_CYC);
    localparam logic [CNT_W-1:0] CNT_ONE = 4'h1;
    localparam logic [CNT_W-1:0] CNT_ZERO = 4'h0;
    typedef enum logic [2:0] {ST_IDLE, ST_WR_SETUP, ST_WR_PULSE, ST_WR_TAIL,
        ST_RD_WAIT, ST_TURN} asramc_state_t;
endpackage : asramc_pkg

/* File: rtl/asramc_ctrl.sv */
// Purpose: Host-side controller driving an asynchronous 1M x 8 static RAM
// Assumes: Pin inputs synchronous to i_core_clk; one request at a time
// Notes: Writes are strobe controlled; reads are output-strobe controlled
// Notes on behaviour
// - Write window is the overlap of strobe low, low select low, high select high.
// - Write data valid at least 25 ns before write end, no hold needed.
// - Address 35 ns before end; select and strobe 35 ns; cycle 45 ns.
// - Address valid at write start and held until write end.
// - Write strobe stays high throughout every read cycle.
// - Controller never drives data pins while the device drives them.
`timescale 1ns/1ps
module asramc_ctrl
(
    input wire logic i_core_clk,
    input wire logic i_arst_n,
    input wire logic i_req_valid,
    input wire logic i_req_write,
    input wire logic [asramc_pkg::ADDR_W-1:0] i_req_addr,
    input wire logic [asramc_pkg::DATA_W-1:0] i_req_wdata,
    output logic o_req_ready,
    output logic o_rd_valid,
    output logic [asramc_pkg::DATA_W-1:0] o_rd_data,
    output logic [asramc_pkg::ADDR_W-1:0] o_word_select_lines,
    output logic o_select_low_active_n,
    output logic o_select_high_active,
    output logic o_write_strobe_n,
    output logic o_output_strobe_n,
    input wire logic [asramc_pkg::DATA_W-1:0] i_shared_byte_lines,
    output logic [asramc_pkg::DATA_W-1:0] o_shared_byte_lines,
    output logic o_shared_byte_lines_oe
);
    asramc_pkg::asramc_state_t state_reg;
    logic [asramc_pkg::CNT_W-1:0] cnt_reg;
    logic [asramc_pkg::ADDR_W-1:0] addr_reg;
    logic [asramc_pkg::DATA_W-1:0] wdata_reg;
    logic sel_reg;
    logic we_n_reg;
    logic oe_n_reg;
    logic drv_reg;
    logic rd_valid_reg;
    logic [asramc_pkg::DATA_W-1:0] rd_data_reg;
    logic cnt_done;

    assign cnt_done = (cnt_reg == asramc_pkg::CNT_ONE);
    assign o_req_ready = (state_reg == asramc_pkg::ST_IDLE);

    // ****************************************************************
    // Sequencer
    // ****************************************************************
    always_ff @(posedge i_core_clk or negedge i_arst_n)
    begin
        if (!i_arst_n)
        begin
            state_reg <= asramc_pkg::ST_IDLE;
            cnt_reg <= asramc_pkg::CNT_ZERO;
        end
        else
        begin
            unique case (state_reg)
                asramc_pkg::ST_IDLE:
                begin
                    if (i_req_valid)
                    begin
                        state_reg <= i_req_write ? asramc_pkg::ST_WR_SETUP
                                                 : asramc_pkg::ST_RD_WAIT;
                        cnt_reg <= i_req_write ? asramc_pkg::WR_PULSE_CNT
                                               : asramc_pkg::RD_WAIT_CNT;
                    end
                end
                // Address and data settle one cycle before the strobe falls
                asramc_pkg::ST_WR_SETUP:
                begin
                    state_reg <= asramc_pkg::ST_WR_PULSE;
                end
                asramc_pkg::ST_WR_PULSE:
                begin
                    if (cnt_done)
                    begin
                        state_reg <= asramc_pkg::ST_WR_TAIL;
                        cnt_reg <= asramc_pkg::WR_TAIL_CNT;
                    end
                    else
                    begin
                        cnt_reg <= cnt_reg - asramc_pkg::CNT_ONE;
                    end
                end
                asramc_pkg::ST_WR_TAIL:
                begin
                    if (cnt_done)
                    begin
                        state_reg <= asramc_pkg::ST_IDLE;
                    end
                    else
                    begin
                        cnt_reg <= cnt_reg - asramc_pkg::CNT_ONE;
                    end
                end
                asramc_pkg::ST_RD_WAIT:
                begin
                    if (cnt_done)
                    begin
                        state_reg <= asramc_pkg::ST_TURN;
                        cnt_reg <= asramc_pkg::TURN_CNT;
                    end
                    else
                    begin
                        cnt_reg <= cnt_reg - asramc_pkg::CNT_ONE;
                    end
                end
                // Device float time after output strobe rises
                asramc_pkg::ST_TURN:
                begin
                    if (cnt_done)
                    begin
                        state_reg <= asramc_pkg::ST_IDLE;
                    end
                    else
                    begin
                        cnt_reg <= cnt_reg - asramc_pkg::CNT_ONE;
                    end
                end
            endcase
        end
    end

    // ****************************************************************
    // Address and write data
    // ****************************************************************
    // address held through write
    always_ff @(posedge i_core_clk or negedge i_arst_n)
    begin
        if (!i_arst_n)
        begin
            addr_reg <= '0;
            wdata_reg <= '0;
        end
        else if (o_req_ready && i_req_valid)
        begin
            addr_reg <= i_req_addr;
            wdata_reg <= i_req_wdata;
        end
    end

    // ****************************************************************
    // Pin strobes
    // ****************************************************************
    // select and strobe overlap
    always_ff @(posedge i_core_clk or negedge i_arst_n)
    begin
        if (!i_arst_n)
        begin
            sel_reg <= 1'b0;
            we_n_reg <= 1'b1;
            oe_n_reg <= 1'b1;
            drv_reg <= 1'b0;
        end
        else
        begin
            sel_reg <= (state_reg == asramc_pkg::ST_IDLE) ? (i_req_valid && !i_req_write)
                : (state_reg == asramc_pkg::ST_WR_SETUP) ||
                  (state_reg == asramc_pkg::ST_WR_PULSE && !cnt_done) ||
                  (state_reg == asramc_pkg::ST_RD_WAIT && !cnt_done);
            we_n_reg <= !((state_reg == asramc_pkg::ST_WR_SETUP) ||
                          (state_reg == asramc_pkg::ST_WR_PULSE && !cnt_done));
            oe_n_reg <= !(((state_reg == asramc_pkg::ST_IDLE) && i_req_valid && !i_req_write) ||
                          (state_reg == asramc_pkg::ST_RD_WAIT && !cnt_done));
            drv_reg <= (state_reg == asramc_pkg::ST_IDLE && i_req_valid && i_req_write) ||
                       (state_reg == asramc_pkg::ST_WR_SETUP) ||
                       (state_reg == asramc_pkg::ST_WR_PULSE && !cnt_done);
        end
    end

    // ****************************************************************
    // Read capture
    // ****************************************************************
    // sample after access time
    always_ff @(posedge i_core_clk or negedge i_arst_n)
    begin
        if (!i_arst_n)
        begin
            rd_valid_reg <= 1'b0;
            rd_data_reg <= '0;
        end
        else
        begin
            rd_valid_reg <= (state_reg == asramc_pkg::ST_RD_WAIT) && cnt_done;
            if ((state_reg == asramc_pkg::ST_RD_WAIT) && cnt_done)
            begin
                rd_data_reg <= i_shared_byte_lines;
            end
        end
    end

    assign o_word_select_lines = addr_reg;
    assign o_select_low_active_n = !sel_reg;
    assign o_select_high_active = sel_reg;
    assign o_write_strobe_n = we_n_reg;
    assign o_output_strobe_n = oe_n_reg;
    assign o_shared_byte_lines = wdata_reg;
    assign o_shared_byte_lines_oe = drv_reg;
    assign o_rd_valid = rd_valid_reg;
    assign o_rd_data = rd_data_reg;

    // ****************************************************************
    // Checks
    // ****************************************************************
    default clocking cb @(posedge i_core_clk); endclocking
    default disable iff (!i_arst_n);

    wr_pulse_len_a: assert property ($fell(we_n_reg) |-> !we_n_reg [*4])
        else $error("write strobe shorter than 35 ns");
    rd_strobe_hi_a: assert property (!oe_n_reg |-> we_n_reg)
        else $error("write strobe low during read");
    no_contend_a: assert property (drv_reg |-> oe_n_reg)
        else $error("controller drives while output strobe low");
    wr_in_sel_a: assert property (!we_n_reg |-> sel_reg && drv_reg)
        else $error("write strobe outside selection");
    addr_hold_a: assert property (!we_n_reg |-> $stable(addr_reg))
        else $error("address moved during write");
    data_setup_a: assert property ($rose(we_n_reg) |-> $past(drv_reg, 3))
        else $error("write data not set up before end");
    rd_wait_a: assert property ($fell(oe_n_reg) |-> oe_n_reg == 1'b0 [*5])
        else $error("read access shorter than 45 ns");
    turn_a: assert property ($rose(oe_n_reg) |-> !drv_reg [*2])
        else $error("drive restarted before device floats");
    wr_period_a: assert property ($fell(we_n_reg) |-> ##[5:8] o_req_ready)
        else $error("write cycle not finished in time");

    wr_cov_c: cover property ($rose(we_n_reg));
    rd_cov_c: cover property (rd_valid_reg);
    rd_wr_c: cover property (rd_valid_reg ##[1:6] !we_n_reg);
endmodule : asramc_ctrl

/* File: dv/asramc_sram_model.sv */
// Purpose: Behavioural 1M x 8 asynchronous static RAM for the controller bench
// Assumes: Pins are polled every 1 ns, half a ns away from the clock edges
// Notes: i_slow selects worst-case access times, otherwise 10 ns
`timescale 1ns/1ps
module asramc_sram_model
(
    input wire logic [asramc_pkg::ADDR_W-1:0] i_word_select_lines,
    input wire logic i_select_low_active_n,
    input wire logic i_select_high_active,
    input wire logic i_write_strobe_n,
    input wire logic i_output_strobe_n,
    input wire logic [asramc_pkg::DATA_W-1:0] i_shared_byte_lines,
    input wire logic i_slow,
    output logic [asramc_pkg::DATA_W-1:0] o_shared_byte_lines,
    output logic o_shared_byte_lines_oe,
    output logic [7:0] o_fault_cnt
);
    // ****************
    // Polled pin model
    // ****************
    logic [asramc_pkg::DATA_W-1:0] mem [logic [asramc_pkg::ADDR_W-1:0]];
    logic [asramc_pkg::ADDR_W-1:0] a_q = '0;
    logic [asramc_pkg::DATA_W-1:0] d_q = '0, last = '0;
    logic idle, wr, rd, ok, wr_q = 1'b0, rd_q = 1'b0;
    realtime t_a = -1e3, t_d = -1e3, t_w = -1e3, t_on = -1e3, acc;
    initial
    begin
        o_fault_cnt = '0;
        o_shared_byte_lines_oe = 1'b0;
        o_shared_byte_lines = '0;
        #0.5;
        forever
        begin
            idle = i_select_low_active_n || !i_select_high_active;
            wr = !idle && !i_write_strobe_n;
            rd = !idle && i_write_strobe_n && !i_output_strobe_n;
            acc = i_slow ? 45.0 : 10.0;
            // write ends at first inactive qualifier
            if (wr_q && !wr)
            begin
                if ($realtime - t_d < 25 || $realtime - t_a < 35 || $realtime - t_w < 35
                    || t_a >= t_w)
                    o_fault_cnt++;
                mem[a_q] = d_q;
            end
            if (wr && !wr_q)
            begin
                if ($realtime - t_w < 45)
                    o_fault_cnt++;
                t_w = $realtime;
            end
            if (i_word_select_lines !== a_q)
                t_a = $realtime;
            if (i_shared_byte_lines !== d_q)
                t_d = $realtime;
            if (rd && !rd_q)
                t_on = $realtime;
            a_q = i_word_select_lines;
            d_q = i_shared_byte_lines;
            wr_q = wr;
            rd_q = rd;
            ok = rd && $realtime - t_a >= acc && $realtime - t_on >= acc;
            if (ok)
                last = mem.exists(a_q) ? mem[a_q] : '0;
            // off in 1 ns, on after 10 ns
            o_shared_byte_lines_oe = rd && $realtime - t_on >= 10;
            o_shared_byte_lines = (ok || $realtime - t_a < 10) ? last : ~last;
            #1;
        end
    end
endmodule : asramc_sram_model

/* File: dv/asramc_ctrl_test.sv */
// Purpose: Self-checking bench for the static RAM controller
// Assumes: Controller at 100 MHz; memory model polls the pins
// Notes: Watchdog ends a hang after 100 us
`timescale 1ns/1ps
module asramc_ctrl_test;
    logic i_core_clk = 1'b0;
    logic i_arst_n = 1'b0;
    logic req_valid = 1'b0, req_write = 1'b0, slow = 1'b0;
    logic [asramc_pkg::ADDR_W-1:0] req_addr = '0, pins_addr;
    logic [asramc_pkg::DATA_W-1:0] req_wdata = '0, rd_data, ctrl_d, mem_d, bus_keep = '0;
    logic ready, rd_valid, sel_n, sel_h, we_n, oe_n, ctrl_oe, mem_oe;
    logic [7:0] fault_cnt;
    wire logic [asramc_pkg::DATA_W-1:0] byte_bus;
    int err_count = 0, samples_checked = 0, pulse = 0;
    always #5 i_core_clk = ~i_core_clk;
    // Released lines show the inverse of the last value so a stale byte never matches
    assign byte_bus = ctrl_oe ? ctrl_d : (mem_oe ? mem_d : ~bus_keep);
    // Enables in the list too, so a driven byte equal to the float value is still kept
    always @* if (ctrl_oe || mem_oe) bus_keep = byte_bus;
    asramc_ctrl asramc_ctrl_i
    (
        .i_core_clk(i_core_clk), .i_arst_n(i_arst_n), .i_req_valid(req_valid),
        .i_req_write(req_write), .i_req_addr(req_addr), .i_req_wdata(req_wdata),
        .o_req_ready(ready), .o_rd_valid(rd_valid), .o_rd_data(rd_data),
        .o_word_select_lines(pins_addr), .o_select_low_active_n(sel_n),
        .o_select_high_active(sel_h), .o_write_strobe_n(we_n), .o_output_strobe_n(oe_n),
        .i_shared_byte_lines(byte_bus), .o_shared_byte_lines(ctrl_d),
        .o_shared_byte_lines_oe(ctrl_oe)
    );
    asramc_sram_model asramc_sram_model_i
    (
        .i_word_select_lines(pins_addr), .i_select_low_active_n(sel_n),
        .i_select_high_active(sel_h), .i_write_strobe_n(we_n), .i_output_strobe_n(oe_n),
        .i_shared_byte_lines(byte_bus), .i_slow(slow), .o_shared_byte_lines(mem_d),
        .o_shared_byte_lines_oe(mem_oe), .o_fault_cnt(fault_cnt)
    );
    // ***************
    // Checks and bus
    // ***************
    task automatic check(input string what, input logic [19:0] exp, input logic [19:0] got);
        samples_checked++;
        if (got !== exp)
        begin
            err_count++;
            $display("unexpected %s: expected %h, seen %h", what, exp, got);
        end
    endtask : check
    task automatic tally_and_finish();
        $display("comparisons %0d, mismatches %0d", samples_checked, err_count);
        if (err_count == 0 && samples_checked > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask : tally_and_finish
    task automatic req(input logic w, input logic [19:0] a, input logic [7:0] d,
        output logic [7:0] q);
        int n;
        n = 0;
        @(posedge i_core_clk);
        req_valid <= 1'b1;
        req_write <= w;
        req_addr <= a;
        req_wdata <= d;
        do @(posedge i_core_clk); while (ready !== 1'b1 && ++n < 30);
        req_valid <= 1'b0;
        if (!w)
        begin
            do @(posedge i_core_clk); while (rd_valid !== 1'b1 && ++n < 30);
            // One-cycle pulse: gone by the next edge
            @(posedge i_core_clk);
            check("read valid pulse", 20'h0, {19'h0, rd_valid});
        end
        q = rd_data;
        if (n >= 30)
            check("handshake wait", 20'h0, 20'h1);
    endtask : req
    always @(negedge i_core_clk)
    begin
        if (ctrl_oe && mem_oe)
            check("bus contention", 20'h0, 20'h1);
        if (!oe_n)
            check("strobe in read", 20'h1, {19'h0, we_n});
        if (!we_n)
        begin
            pulse++;
            check("select in write", 20'h1, {19'h0, !sel_n && sel_h});
        end
        else if (pulse != 0)
        begin
            check("pulse cycles", 20'(asramc_pkg::WR_PULSE_CYC), 20'(pulse));
            pulse = 0;
        end
    end
    // *********
    // Scenarios
    // *********
    task automatic t_reset();
        @(posedge i_core_clk);
        i_arst_n <= 1'b0;
        repeat (3) @(posedge i_core_clk);
        check("idle pins", 20'h5a, {13'h0, sel_n, sel_h, we_n, oe_n, ctrl_oe, ready, rd_valid});
        i_arst_n <= 1'b1;
    endtask : t_reset
    task automatic t_rw_table();
        logic [19:0] a [4] = '{20'h00000, 20'hfffff, 20'h5a5a5, 20'h80001};
        logic [7:0] q;
        for (int m = 0; m < 2; m++)
        begin
            slow = m[0];
            foreach (a[k]) req(1'b1, a[k], a[k][7:0] ^ {m[0], 7'h3c}, q);
            foreach (a[k])
            begin
                req(1'b0, a[k], 8'h00, q);
                check("read byte", {12'h0, a[k][7:0] ^ {m[0], 7'h3c}}, {12'h0, q});
            end
        end
    endtask : t_rw_table
    task automatic t_refused();
        logic [7:0] q;
        req(1'b1, 20'h12345, 8'ha5, q);
        @(posedge i_core_clk);
        req_valid <= 1'b1;
        req_wdata <= 8'h5a;
        repeat (3) @(posedge i_core_clk) check("ready while busy", 20'h0, {19'h0, ready});
        req_valid <= 1'b0;
        req(1'b0, 20'h12345, 8'h00, q);
        check("refused write", 20'ha5, {12'h0, q});
    endtask : t_refused
    task automatic t_keep();
        logic [7:0] q;
        req(1'b0, 20'h12345, 8'h00, q);
        check("byte across reset", 20'ha5, {12'h0, q});
    endtask : t_keep
    initial
    begin
        t_reset();
        t_rw_table();
        t_refused();
        t_reset();
        t_keep();
        check("timing faults", 20'h0, {12'h0, fault_cnt});
        tally_and_finish();
    end
    initial
    begin
        #100000;
        err_count++;
        tally_and_finish();
    end
endmodule : asramc_ctrl_test
